// [core/fault_queue.sv]
`timescale 1ns/1ps
`include "temp_cfg.svh"

module fault_queue (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// conversion events
	input  wire logic       i_conv_done,
	input  wire logic       i_fault_crit,
	input  wire logic       i_fault_limit,
	input  wire logic [1:0] i_depth,
	// alert levels
	output logic            o_critical_alert_pin,
	output logic            o_limit_alert_pin
);
	import temp_pkg::*;

	logic [2:0] count_reg;
	logic [2:0] count_next;
	logic       crit_reg;
	logic       crit_next;
	logic       limit_reg;
	logic       limit_next;
	logic [2:0] depth;

	always_comb begin
		count_next = count_reg;
		crit_next  = crit_reg;
		limit_next = limit_reg;
		depth      = {1'b0, i_depth} + 3'h1;
		if (i_conv_done) begin
			if (i_fault_crit | i_fault_limit) begin
				if (count_reg != `FAULT_CNT_MAX) begin
					count_next = count_reg + 3'h1;
				end
				if (count_reg + 3'h1 >= depth) begin
					crit_next  = i_fault_crit;
					limit_next = i_fault_limit;
				end
			end else begin
				count_next = 3'h0;
				crit_next  = 1'b0;
				limit_next = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			count_reg <= 3'h0;
			crit_reg  <= 1'b0;
			limit_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			crit_reg  <= crit_next;
			limit_reg <= limit_next;
		end
	end

	assign o_critical_alert_pin = crit_reg;
	assign o_limit_alert_pin    = limit_reg;
endmodule

// [core/spi_sync.sv]
`timescale 1ns/1ps
`include "temp_cfg.svh"

module spi_sync (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_reset,
	// raw pins
	input  wire temp_pkg::serial_in_type i_pins,
	// synchronised pins and edges
	output temp_pkg::serial_in_type      o_pins,
	output logic                         o_sclk_rise,
	output logic                         o_sclk_fall
);
	import temp_pkg::*;

	serial_in_type meta_reg;
	serial_in_type sync_reg;
	logic          sclk_last_reg;
	serial_in_type meta_next;
	serial_in_type sync_next;
	logic          sclk_last_next;

	always_comb begin
		meta_next      = i_pins;
		sync_next      = meta_reg;
		sclk_last_next = sync_reg.sclk;
	end

	// idle: deselected, clock high
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			meta_reg      <= 3'h6;
			sync_reg      <= 3'h6;
			sclk_last_reg <= 1'b1;
		end else begin
			meta_reg      <= meta_next;
			sync_reg      <= sync_next;
			sclk_last_reg <= sclk_last_next;
		end
	end

	assign o_pins      = sync_reg;
	assign o_sclk_rise = sync_reg.sclk & ~sclk_last_reg;
	assign o_sclk_fall = ~sync_reg.sclk & sclk_last_reg;
endmodule

// [core/spi_temp_readout.sv]
`timescale 1ns/1ps
`include "temp_cfg.svh"

module spi_temp_readout #(
	parameter int unsigned CONV_CYCLES  = `CONV_TIME_MS * `CLK_FREQ_KHZ,
	parameter int unsigned BLOCK_CYCLES = `BLOCK_CYCLES
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	// serial port pins
	input  wire logic        i_sclk,
	input  wire logic        i_cs_n,
	input  wire logic        i_din,
	output logic             o_dout,
	output logic             o_dout_oe,
	// converter side
	input  wire logic [15:0] i_adc_code,
	output logic             o_conv_done,
	output logic             o_conv_busy,
	output logic             o_shutdown,
	// alerts
	output logic             o_critical_alert_pin,
	output logic             o_limit_alert_pin
);
	import temp_pkg::*;

	// signed 13-bit compare of two stored words
	function automatic logic above(input logic [15:0] a, input logic [15:0] b);
		above = $signed(a[`CODE_MSB:`CODE_LSB]) > $signed(b[`CODE_MSB:`CODE_LSB]);
	endfunction

	// limit flags of one code against the fixed setpoints
	function automatic limit_flags_type check_limits(input logic [15:0] code);
		limit_flags_type f;
		f.crit = above(code, `CRIT_SETPOINT);
		f.high = above(code, `HIGH_SETPOINT);
		f.low  = above(`LOW_SETPOINT, code);
		return f;
	endfunction

	// 13-bit words carry the limit flags in the low bits
	function automatic logic [15:0] format_word(input cfg_type c, input logic [15:0] r,
		input limit_flags_type f);
		logic [15:0] w;
		if (c.res16) begin
			w = r;
		end else begin
			w = {r[`CODE_MSB:`CODE_LSB], f};
		end
		return w;
	endfunction

	// first fall of a read frame loads a fresh word
	function automatic logic loads_word(input port_state_type st, input logic [4:0] cnt);
		return (st == st_rdata || st == st_cont) && cnt == 5'h00;
	endfunction

	serial_in_type   pins;
	logic            sclk_rise;
	logic            sclk_fall;

	port_state_type  state_reg;
	port_state_type  state_next;
	logic [4:0]      cnt_reg;
	logic [4:0]      cnt_next;
	logic [7:0]      shin_reg;
	logic [7:0]      shin_next;
	logic [15:0]     shout_reg;
	logic [15:0]     shout_next;
	logic [2:0]      addr_reg;
	logic [2:0]      addr_next;
	logic [5:0]      ones_reg;
	logic [5:0]      ones_next;
	cfg_type         cfg_reg;
	cfg_type         cfg_next;

	logic [`CONV_CNT_W-1:0] conv_cnt_reg;
	logic [`CONV_CNT_W-1:0] conv_cnt_next;
	logic [15:0]     result_reg;
	logic [15:0]     result_next;
	limit_flags_type flags_reg;
	limit_flags_type flags_next;
	logic            done_reg;
	logic            done_next;

	limit_flags_type flags_now;
	logic [7:0]      byte_in;
	logic [15:0]     temp_word;
	logic [15:0]     read_word;
	logic            shutdown;
	logic            busy;
	logic            shutdown_out_reg;
	logic            shutdown_out_next;
	logic            busy_out_reg;
	logic            busy_out_next;

	spi_sync u_sync (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_pins      ({i_cs_n, i_sclk, i_din}),
		.o_pins      (pins),
		.o_sclk_rise (sclk_rise),
		.o_sclk_fall (sclk_fall)
	);

	fault_queue u_queue (
		.i_clk                (i_clk),
		.i_reset              (i_reset),
		.i_conv_done          (done_reg),
		.i_fault_crit         (flags_reg.crit),
		.i_fault_limit        (flags_reg.high | flags_reg.low),
		.i_depth              (cfg_reg.fault_depth),
		.o_critical_alert_pin (o_critical_alert_pin),
		.o_limit_alert_pin    (o_limit_alert_pin)
	);

	// conversion timing and result store
	always_comb begin
		shutdown        = cfg_reg.op_mode == `MODE_SHUTDOWN;
		conv_cnt_next   = conv_cnt_reg;
		result_next     = result_reg;
		flags_next      = flags_reg;
		done_next       = 1'b0;
		flags_now       = check_limits(i_adc_code);
		busy            = !shutdown &&
			conv_cnt_reg >= `CONV_CNT_W'(CONV_CYCLES - BLOCK_CYCLES);
		if (shutdown) begin
			conv_cnt_next = '0;
		end else if (conv_cnt_reg == `CONV_CNT_W'(CONV_CYCLES - 1)) begin
			conv_cnt_next = '0;
			result_next   = i_adc_code;
			flags_next    = flags_now;
			done_next     = 1'b1;
		end else begin
			conv_cnt_next = conv_cnt_reg + `CONV_CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			conv_cnt_reg <= '0;
			result_reg   <= `RESULT_RESET;
			flags_reg    <= 3'h0;
			done_reg     <= 1'b0;
		end else begin
			conv_cnt_reg <= conv_cnt_next;
			result_reg   <= result_next;
			flags_reg    <= flags_next;
			done_reg     <= done_next;
		end
	end

	// word presented for reads
	always_comb begin
		temp_word = format_word(cfg_reg, result_reg, flags_reg);
		if (state_reg == st_cont) begin
			read_word = busy ? 16'h0000 : temp_word;
		end else if (addr_reg == `ADDR_TEMP) begin
			read_word = temp_word;
		end else if (addr_reg == `ADDR_CFG) begin
			read_word = {cfg_reg, 8'h00};
		end else begin
			read_word = 16'h0000;
		end
	end

	// status outputs from flip-flops, one cycle behind the counter and cfg_reg
	always_comb begin
		shutdown_out_next = shutdown;
		busy_out_next     = busy;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			shutdown_out_reg <= 1'b0;
			busy_out_reg     <= 1'b0;
		end else begin
			shutdown_out_reg <= shutdown_out_next;
			busy_out_reg     <= busy_out_next;
		end
	end

	// serial port
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		shin_next  = shin_reg;
		shout_next = shout_reg;
		addr_next  = addr_reg;
		ones_next  = ones_reg;
		cfg_next   = cfg_reg;
		byte_in    = {shin_reg[6:0], pins.din};
		if (pins.cs_n) begin
			cnt_next  = 5'h00;
			ones_next = 6'h00;
			if (state_reg != st_cont) begin
				state_next = st_cmd;
			end
		end else if (sclk_rise) begin
			shin_next = byte_in;
			cnt_next  = cnt_reg + 5'h01;
			ones_next = pins.din ? ones_reg + 6'h01 : 6'h00;
			case (state_reg)
				st_cmd: begin
					if (cnt_reg == `BYTE_LAST) begin
						cnt_next  = 5'h00;
						addr_next = byte_in[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
						if (byte_in == `CMD_CONT_ENTER) begin
							state_next = st_cont;
						end else if (byte_in[`CMD_RW_BIT]) begin
							state_next = st_rdata;
						end else begin
							state_next = st_wdata;
						end
					end
				end
				st_wdata: begin
					if (cnt_reg == `BYTE_LAST) begin
						cnt_next   = 5'h00;
						state_next = st_cmd;
						if (addr_reg == `ADDR_CFG) begin
							cfg_next = byte_in;
						end
					end
				end
				st_rdata: begin
					if (cnt_reg == `FRAME_BITS) begin
						cnt_next = cnt_reg;
					end
				end
				st_cont: begin
					if (cnt_reg == `FRAME_LAST) begin
						cnt_next = 5'h00;
					end
					if (cnt_reg[2:0] == `BYTE_LAST_LOW && byte_in == `CMD_CONT_EXIT) begin
						state_next = st_cmd;
						cnt_next   = 5'h00;
					end
				end
				default: begin
					state_next = st_cmd;
				end
			endcase
			if (pins.din && ones_reg + 6'h01 == `ONES_LIMIT) begin
				state_next = st_cmd;
				cnt_next   = 5'h00;
				ones_next  = 6'h00;
			end
		end else if (sclk_fall) begin
			if (loads_word(state_reg, cnt_reg)) begin
				shout_next = read_word;
			end else begin
				shout_next = {shout_reg[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_reg <= st_cmd;
			cnt_reg   <= 5'h00;
			shin_reg  <= 8'h00;
			shout_reg <= 16'h0000;
			addr_reg  <= 3'h0;
			ones_reg  <= 6'h00;
			cfg_reg   <= `CFG_RESET;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			shin_reg  <= shin_next;
			shout_reg <= shout_next;
			addr_reg  <= addr_next;
			ones_reg  <= ones_next;
			cfg_reg   <= cfg_next;
		end
	end

	assign o_dout      = shout_reg[15];
	assign o_dout_oe   = ~pins.cs_n;
	assign o_conv_done = done_reg;
	assign o_conv_busy = busy_out_reg;
	assign o_shutdown  = shutdown_out_reg;
endmodule

// [core/temp_cfg.svh]
`ifndef TEMP_CFG_SVH
`define TEMP_CFG_SVH

// clock and conversion timing
`define CLK_FREQ_KHZ     100000
`define CONV_TIME_MS     240
`define BLOCK_CYCLES     16
`define CONV_CNT_W       25

// command byte layout and codes
`define CMD_CONT_ENTER   8'h54
`define CMD_CONT_EXIT    8'h50
`define CMD_RW_BIT       6
`define CMD_ADDR_MSB     5
`define CMD_ADDR_LSB     3
`define ADDR_CFG         3'h1
`define ADDR_TEMP        3'h2

// serial framing
`define BYTE_LAST        5'h07
`define BYTE_LAST_LOW    3'h7
`define FRAME_LAST       5'h0f
`define FRAME_BITS       5'h10
`define ONES_LIMIT       6'h20

// reset values and shutdown mode code
`define CFG_RESET        8'h00
`define RESULT_RESET     16'h0000
`define MODE_SHUTDOWN    2'h3

// limit setpoints, 13-bit code in bits 15:3
`define CRIT_SETPOINT    16'h4980
`define HIGH_SETPOINT    16'h2000
`define LOW_SETPOINT     16'h0500
`define CODE_MSB         15
`define CODE_LSB         3

// fault queue
`define FAULT_CNT_MAX    3'h4

`endif

// [core/temp_pkg.sv]
package temp_pkg;

	typedef enum logic [1:0] {
		st_cmd   = 2'h0,
		st_rdata = 2'h1,
		st_cont  = 2'h3,
		st_wdata = 2'h2
	} port_state_type;

	typedef struct packed {
		logic       res16;
		logic [1:0] op_mode;
		logic       alert_mode;
		logic       int_pol;
		logic       crit_pol;
		logic [1:0] fault_depth;
	} cfg_type;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} serial_in_type;

	// bit 0 critical, bit 1 upper, bit 2 lower
	typedef struct packed {
		logic low;
		logic high;
		logic crit;
	} limit_flags_type;

endpackage

// [tb/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_din,
	input  wire logic i_dout
);
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_din = 1'b0;
	end
	// n bits msb first, clock idles high; dout taken at end of high phase
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0;
		o_cs_n = 1'b0;
		#20;
		for (int k = n - 1; k >= 0; k--) begin
			o_sclk = 1'b0;
			o_din = tx[k];
			#40;
			o_sclk = 1'b1;
			#40;
			rx[k] = i_dout;
		end
		o_din = 1'b0;
		o_cs_n = 1'b1;
		#200;
	endtask
endmodule

// [tb/spi_temp_readout_checker.sv]
`timescale 1ns/1ps
module spi_temp_readout_checker #(
	parameter int unsigned CONV_CYCLES  = 200,
	parameter int unsigned BLOCK_CYCLES = 16
) (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        i_sclk,
	input wire logic        i_cs_n,
	input wire logic        i_din,
	input wire logic        o_dout,
	input wire logic        o_dout_oe,
	input wire logic [15:0] i_adc_code,
	input wire logic        o_conv_done,
	input wire logic        o_conv_busy,
	input wire logic        o_shutdown,
	input wire logic        o_critical_alert_pin,
	input wire logic        o_limit_alert_pin
);
	localparam int WAKE_LO = CONV_CYCLES - 2;
	localparam int WAKE_HI = CONV_CYCLES + 2;
	localparam int BUSY_HI = BLOCK_CYCLES + 1;
	logic [31:0] gap_reg;
	logic [31:0] gap_next;
	logic        armed_reg;
	logic        armed_next;
	// cycles since the last result, valid once a result was seen
	always_comb begin
		gap_next = (i_reset | o_conv_done) ? 32'h0 : gap_reg + 32'h1;
		armed_next = ~i_reset & (armed_reg | o_conv_done) & ~o_shutdown;
	end
	always_ff @(posedge i_clk) begin
		gap_reg <= gap_next;
		armed_reg <= armed_next;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	conv_period_a: assert property (
		armed_reg && !o_shutdown |-> o_conv_done == (gap_reg == CONV_CYCLES - 1))
		else $error("conversion period wrong");
	wake_conv_a: assert property (
		$fell(o_shutdown) |-> ##[WAKE_LO:WAKE_HI] o_conv_done)
		else $error("no conversion after wake");
	busy_end_a: assert property (
		$rose(o_conv_busy) |-> ##[1:BUSY_HI] o_conv_done)
		else $error("busy window not closed by result");
	shutdown_quiet_a: assert property (
		o_shutdown && $past(o_shutdown) |-> !o_conv_done && !o_conv_busy)
		else $error("converting in shutdown");
	crit_update_a: assert property (
		$changed(o_critical_alert_pin) |-> $past(o_conv_done))
		else $error("critical alert moved without result");
	limit_update_a: assert property (
		$changed(o_limit_alert_pin) |-> $past(o_conv_done))
		else $error("limit alert moved without result");
	crit_limit_a: assert property (
		o_critical_alert_pin |-> o_limit_alert_pin)
		else $error("critical alert without upper alert");
	dout_hold_a: assert property (
		(i_sclk && !i_cs_n)[*5] |-> $stable(o_dout))
		else $error("dout moved while clock high");
	oe_select_a: assert property (
		(!i_cs_n)[*3] |-> o_dout_oe)
		else $error("output enable low while selected");
	oe_release_a: assert property (
		i_cs_n[*3] |-> !o_dout_oe)
		else $error("output enable high while deselected");
	cover property (o_conv_done);
	cover property ($fell(o_shutdown));
	cover property ($rose(o_critical_alert_pin));
endmodule

bind spi_temp_readout spi_temp_readout_checker #(
	.CONV_CYCLES(CONV_CYCLES),
	.BLOCK_CYCLES(BLOCK_CYCLES)
) i_checker (
	.i_clk(i_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
	.i_din(i_din), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .i_adc_code(i_adc_code),
	.o_conv_done(o_conv_done), .o_conv_busy(o_conv_busy), .o_shutdown(o_shutdown),
	.o_critical_alert_pin(o_critical_alert_pin), .o_limit_alert_pin(o_limit_alert_pin)
);

// [tb/test_spi_temp_readout.sv]
`timescale 1ns/1ps
module test_spi_temp_readout;
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic [15:0] i_adc_code = 16'h0000;
	logic        sclk, cs_n, din, dout, dout_oe;
	logic        done, busy, sdown, crit, lim;
	logic [31:0] rx;
	int          failures = 0;
	int          tests_run = 0;
	always #5 i_clk = ~i_clk;
	spi_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
	spi_temp_readout #(.CONV_CYCLES(200), .BLOCK_CYCLES(16)) i_dut (
		.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
		.o_dout(dout), .o_dout_oe(dout_oe), .i_adc_code(i_adc_code),
		.o_conv_done(done), .o_conv_busy(busy), .o_shutdown(sdown),
		.o_critical_alert_pin(crit), .o_limit_alert_pin(lim));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic cmd(input int n, input logic [31:0] tx);
		i_host.xfer(n, tx, rx);
	endtask
	task automatic adc(input logic [15:0] v);
		tick(1);
		i_adc_code = v;
	endtask
	task automatic rres(input logic [15:0] exp);
		cmd(24, 32'h00500000);
		check(rx[15:0], exp);
	endtask
	task automatic rcfg(input logic [7:0] exp);
		cmd(16, 32'h00004800);
		check(rx[15:0], {8'h00, exp});
	endtask
	task automatic wcfg(input logic [7:0] v);
		cmd(16, {16'h0000, 8'h08, v});
	endtask
	task automatic wait_done;
		int k;
		k = 0;
		while (done !== 1'b1 && k < 400) begin
			k++;
			tick(1);
		end
		check({15'h0000, k < 400}, 16'h0001);
		tick(1);
	endtask
	task automatic t_reset;
		check({15'h0000, dout_oe}, 16'h0000);
		rres(16'h0000);
		rcfg(8'h00);
	endtask
	task automatic t_format;
		adc(16'hf385);
		wait_done;
		rres(16'hf384);
		wcfg(8'h80);
		rcfg(8'h80);
		cmd(16, 32'h000010ff);
		rcfg(8'h80);
		cmd(16, 32'h00004000);
		check(rx[15:0], 16'h0000);
		wait_done;
		rres(16'hf385);
		wcfg(8'h00);
	endtask
	task automatic t_fault;
		for (int d = 0; d < 4; d++) begin
			adc(16'h0c80);
			wcfg(d[7:0]);
			wait_done;
			check({14'h0000, crit, lim}, 16'h0000);
			adc(16'h5000);
			for (int i = 0; i <= d; i++) begin
				wait_done;
				check({14'h0000, crit, lim}, (i == d) ? 16'h0003 : 16'h0000);
			end
		end
		rres(16'h5003);
		wcfg(8'h00);
	endtask
	task automatic t_cont;
		int k;
		adc(16'h0c80);
		wait_done;
		cmd(8, 32'h54);
		cmd(16, 32'h0);
		check(rx[15:0], 16'h0c80);
		adc(16'h1900);
		wait_done;
		cmd(16, 32'h0);
		check(rx[15:0], 16'h1900);
		k = 0;
		while (busy !== 1'b1 && k < 400) begin
			k++;
			tick(1);
		end
		check({15'h0000, k < 400}, 16'h0001);
		cmd(16, 32'h0);
		check(rx[15:0], 16'h0000);
		cmd(16, 32'h5000);
		rres(16'h1900);
		cmd(8, 32'h54);
		cmd(32, 32'hffffffff);
		rres(16'h1900);
	endtask
	task automatic t_shutdown;
		int n;
		adc(16'h0c80);
		wait_done;
		wcfg(8'h60);
		adc(16'h5000);
		n = 0;
		repeat (400) begin
			tick(1);
			if (done !== 1'b0) n++;
		end
		check({15'h0000, sdown}, 16'h0001);
		check(n[15:0], 16'h0000);
		rcfg(8'h60);
		rres(16'h0c80);
		wcfg(8'h00);
		wait_done;
		rres(16'h5003);
	endtask
	task automatic results;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		tick(4);
		i_reset = 1'b0;
		tick(4);
		t_reset;
		t_format;
		t_fault;
		t_cont;
		t_shutdown;
		results;
	end
	// tests take about 83 us, limit leaves ample margin
	initial begin
		#400000;
		failures++;
		results;
	end
endmodule
